// ==== link_tx_ctrl.sv ====
// transmit link control: sync handshake, framing, replacement, self-test
// assumes sync pins are asynchronous; symbols go to an external 8b/10b
`timescale 1ns/10ps
`default_nettype none
`include "link_tx_consts.svh"
module link_tx_ctrl #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8,
  parameter int ILA_MULTIFRAMES = 4,
  parameter int FRAMES_PER_MF = 16
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic LINK_SYNC_REQUEST_POS,
  input wire logic LINK_SYNC_REQUEST_NEG,
  input wire link_tx_pkg::link_cfg_s CFG,
  input wire logic [WIDTH-1:0] SAMPLE,
  input wire logic SAMPLE_VALID,
  output logic SAMPLE_READY,
  output link_tx_pkg::symbol_s SYMBOL,
  output logic SYMBOL_VALID,
  output logic PLL_LOW_BW,
  output link_tx_pkg::link_state_e LINK_STATE,
  output logic BIST_BUSY,
  output logic [15:0] BIST_SIG_A,
  output logic [15:0] BIST_SIG_B
);
  import link_tx_pkg::*;
  localparam int FW = $clog2(FRAMES_PER_MF);
  localparam int IW = $clog2(ILA_MULTIFRAMES * FRAMES_PER_MF * 2 + 1);

  // two-stage synchronisers on both pin legs
  logic pos_s1, pos_s2, neg_s1, neg_s2;
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pos_s1 <= 1'b1;
      pos_s2 <= 1'b1;
      neg_s1 <= 1'b0;
      neg_s2 <= 1'b0;
    end else begin
      pos_s1 <= LINK_SYNC_REQUEST_POS;
      pos_s2 <= pos_s1;
      neg_s1 <= LINK_SYNC_REQUEST_NEG;
      neg_s2 <= neg_s1;
    end
  end

  logic link_sync_request;
  assign link_sync_request = CFG.sync_cmos ? pos_s2 : (pos_s2 | ~neg_s2);

  assign PLL_LOW_BW = ~CFG.pll_low_rate;

  // self-test state
  logic [9:0] bist_cnt, next_bist_cnt;
  logic bist_run, next_bist_run, bist_en_d, next_bist_en_d;
  logic [14:0] pn, next_pn;
  logic [15:0] sig_a, sig_b, next_sig_a, next_sig_b;
  logic [15:0] next_bist_sig_a, next_bist_sig_b;

  // sample fifo
  logic [WIDTH-1:0] fifo_in, fifo_out;
  logic fifo_out_valid, fifo_out_ready;
  link_tx_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk(CORE_CLK),
    .resetn(RESETN),
    .in_data(fifo_in),
    .in_valid(SAMPLE_VALID || bist_run),
    .in_ready(SAMPLE_READY),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  assign fifo_in = bist_run ? pn[WIDTH-1:0] : SAMPLE;

  always_comb begin
    next_bist_en_d = CFG.bist_en;
    next_bist_run = bist_run;
    next_bist_cnt = bist_cnt;
    next_pn = pn;
    next_sig_a = sig_a;
    next_sig_b = sig_b;
    next_bist_sig_a = BIST_SIG_A;
    next_bist_sig_b = BIST_SIG_B;
    if (CFG.bist_en && !bist_en_d) begin
      next_bist_run = 1'b1;
      next_bist_cnt = '0;
      next_sig_a = `SIG_SEED;
      next_sig_b = `SIG_SEED;
      if (CFG.bist_pn_restart) begin
        next_pn = `PN_SEED;
      end
    end else if (bist_run && SAMPLE_READY) begin
      next_pn = {pn[13:0], pn[14] ^ pn[13]};
      next_sig_a = {sig_a[14:0], sig_a[15] ^ sig_a[4] ^ sig_a[2] ^ sig_a[1]}
                   ^ {2'b00, pn[13:0]};
      next_sig_b = {sig_b[14:0], sig_b[15] ^ sig_b[4] ^ sig_b[2] ^ sig_b[1]}
                   ^ {2'b00, ~pn[13:0]};
      next_bist_cnt = bist_cnt + 1'b1;
      if (next_bist_cnt == `BIST_LEN) begin
        next_bist_run = 1'b0;
        next_bist_sig_a = next_sig_a;
        next_bist_sig_b = next_sig_b;
      end
    end
  end
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      bist_en_d <= 1'b0;
      bist_run <= 1'b0;
      bist_cnt <= '0;
      pn <= `PN_SEED;
      sig_a <= `SIG_SEED;
      sig_b <= `SIG_SEED;
      BIST_SIG_A <= '0;
      BIST_SIG_B <= '0;
    end else begin
      bist_en_d <= next_bist_en_d;
      bist_run <= next_bist_run;
      bist_cnt <= next_bist_cnt;
      pn <= next_pn;
      sig_a <= next_sig_a;
      sig_b <= next_sig_b;
      BIST_SIG_A <= next_bist_sig_a;
      BIST_SIG_B <= next_bist_sig_b;
    end
  end
  assign BIST_BUSY = bist_run;

  // formatting of the sample at the fifo output
  logic [WIDTH-1:0] fmt;
  always_comb begin
    fmt = fifo_out;
    case (CFG.data_format)
      `FMT_OFFSET: fmt = {~fifo_out[WIDTH-1], fifo_out[WIDTH-2:0]};
      `FMT_GRAY: begin
        fmt = {~fifo_out[WIDTH-1], fifo_out[WIDTH-2:0]};
        fmt = fmt ^ (fmt >> 1);
      end
      default: fmt = fifo_out;
    endcase
    if (CFG.invert) begin
      fmt = ~fmt;
    end
  end

  // link state machine and framer
  link_state_e state, next_state;
  logic [1:0] low_cnt, next_low_cnt;
  logic octet_sel, next_octet_sel;
  logic [7:0] second, next_second, prev_last, next_prev_last;
  logic [FW-1:0] frame_cnt, next_frame_cnt;
  logic [IW-1:0] ila_cnt, next_ila_cnt;
  logic [14:0] scr, next_scr;
  symbol_s next_symbol;
  logic next_symbol_valid;
  logic mf_end;
  logic [7:0] raw, scr_out;

  assign mf_end = (frame_cnt == FW'(FRAMES_PER_MF - 1));

  always_comb begin
    next_state = state;
    next_low_cnt = link_sync_request ? 2'd0
                 : ((low_cnt == `SYNC_LOW_MIN) ? low_cnt : low_cnt + 2'd1);
    next_octet_sel = octet_sel;
    next_second = second;
    next_prev_last = prev_last;
    next_frame_cnt = frame_cnt;
    next_ila_cnt = ila_cnt;
    next_scr = scr;
    next_symbol = SYMBOL;
    next_symbol_valid = 1'b1;
    fifo_out_ready = 1'b0;
    raw = '0;
    scr_out = '0;
    case (state)
      ST_IDLE: begin
        next_symbol = '{octet: `K28_5, is_k: 1'b1};
        if (next_low_cnt == `SYNC_LOW_MIN) begin
          next_state = ST_CGS;
        end
      end
      ST_CGS: begin
        next_symbol = '{octet: `K28_5, is_k: 1'b1};
        next_octet_sel = 1'b0;
        next_frame_cnt = '0;
        next_ila_cnt = '0;
        next_scr = `SCR_SEED;
        // release leads to alignment or data
        if (link_sync_request) begin
          next_state = (CFG.ila_mode != `ILA_OFF) ? ST_ILA : ST_DATA;
        end
      end
      ST_ILA: begin
        // alignment starts on a frame boundary
        next_symbol = '{octet: `ILA_K28_0, is_k: 1'b1};
        if (ila_cnt == '0) begin
          next_symbol = '{octet: `ILA_K28_0, is_k: 1'b1};
        end else if (ila_cnt[IW-1:0] ==
                     IW'(ILA_MULTIFRAMES * FRAMES_PER_MF * 2 - 1)) begin
          next_symbol = '{octet: `K28_3, is_k: 1'b1};
        end else if (ila_cnt[$clog2(FRAMES_PER_MF * 2)-1:0] ==
                     '1) begin
          next_symbol = '{octet: `K28_3, is_k: 1'b1};
        end else begin
          next_symbol = '{octet: 8'(ila_cnt), is_k: 1'b0};
        end
        next_ila_cnt = ila_cnt + 1'b1;
        if (ila_cnt == IW'(ILA_MULTIFRAMES * FRAMES_PER_MF * 2 - 1)) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (!octet_sel) begin
          // first data octet opens a frame
          next_symbol_valid = fifo_out_valid;
          fifo_out_ready = 1'b1;
          raw = fmt[`MSB_SEL -: 8];
          next_second = {fmt[5:0], CFG.tail_bits};
          next_octet_sel = fifo_out_valid;
        end else begin
          raw = second;
          next_octet_sel = 1'b0;
        end
        scr_out = raw;
        if (CFG.scramble_en) begin
          for (int i = 7; i >= 0; i--) begin
            scr_out[i] = raw[i] ^ next_scr[13] ^ next_scr[14];
            next_scr = {next_scr[13:0], scr_out[i]};
          end
        end
        next_symbol = '{octet: scr_out, is_k: 1'b0};
        if (octet_sel) begin
          next_prev_last = scr_out;
          next_frame_cnt = mf_end ? '0 : frame_cnt + 1'b1;
          if (!CFG.scramble_en && scr_out == prev_last) begin
            next_symbol = '{octet: (CFG.lane_sync_en && mf_end) ? `K28_3
                                   : `K28_7, is_k: 1'b1};
          end else if (CFG.scramble_en && CFG.lane_sync_en && mf_end
                       && scr_out == `D28_3) begin
            next_symbol = '{octet: `K28_3, is_k: 1'b1};
          end else if (CFG.scramble_en && scr_out == `D28_7) begin
            next_symbol = '{octet: `K28_7, is_k: 1'b1};
          end
        end
        if (!next_symbol_valid) begin
          next_symbol = SYMBOL;
          next_scr = scr;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (state != ST_CGS && state != ST_IDLE
        && next_low_cnt == `SYNC_LOW_MIN) begin
      next_state = ST_CGS;
      next_symbol = '{octet: `K28_5, is_k: 1'b1};
      next_symbol_valid = 1'b1;
      next_octet_sel = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= ST_IDLE;
      low_cnt <= '0;
      octet_sel <= 1'b0;
      second <= '0;
      prev_last <= '0;
      frame_cnt <= '0;
      ila_cnt <= '0;
      scr <= `SCR_SEED;
      SYMBOL <= '{octet: `K28_5, is_k: 1'b1};
      SYMBOL_VALID <= 1'b0;
    end else begin
      state <= next_state;
      low_cnt <= next_low_cnt;
      octet_sel <= next_octet_sel;
      second <= next_second;
      prev_last <= next_prev_last;
      frame_cnt <= next_frame_cnt;
      ila_cnt <= next_ila_cnt;
      scr <= next_scr;
      SYMBOL <= next_symbol;
      SYMBOL_VALID <= next_symbol_valid;
    end
  end
  assign LINK_STATE = state;
endmodule : link_tx_ctrl
`default_nettype wire

// ==== link_tx_consts.svh ====
// constants for the serial link transmit controller
// assumes one 100 MHz core clock; included by bare name
`ifndef LINK_TX_CONSTS_SVH
`define LINK_TX_CONSTS_SVH
`define SYNC_LOW_MIN 2'd2
`define K28_5 8'hbc
`define K28_7 8'hfc
`define K28_3 8'h7c
`define D28_7 8'hfc
`define D28_3 8'h7c
`define ILA_K28_0 8'h1c
`define BIST_LEN 10'd512
`define PN_SEED 15'h0092
`define SIG_SEED 16'hffff
`define SCR_SEED 15'h7fff
`define FMT_TWOS 2'd0
`define FMT_OFFSET 2'd1
`define FMT_GRAY 2'd2
`define ILA_OFF 2'd0
`define MSB_SEL 13
`endif

// ==== link_tx_pkg.sv ====
// types for the serial link transmit controller
// assumes the constants header is included alongside
package link_tx_pkg;
  typedef struct packed {
    logic [7:0] octet;
    logic is_k;
  } symbol_s;
  typedef struct packed {
    logic [1:0] data_format;
    logic invert;
    logic scramble_en;
    logic lane_sync_en;
    logic [1:0] ila_mode;
    logic sync_cmos;
    logic pll_low_rate;
    logic bist_en;
    logic bist_pn_restart;
    logic [1:0] tail_bits;
  } link_cfg_s;
  typedef enum logic [1:0] {ST_IDLE, ST_CGS, ST_ILA, ST_DATA} link_state_e;
endpackage : link_tx_pkg

// ==== link_tx_fifo.sv ====
// sample fifo between converter core and link framer
// assumes a single clock and active low asynchronous reset
`timescale 1ns/10ps
`default_nettype none
module link_tx_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;
  always_comb begin
    in_ready = (count != (AW+1)'(DEPTH));
    out_valid = (count != '0);
    out_data = mem[rd_ptr];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1)
                       : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1)
                      : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : link_tx_fifo
`default_nettype wire

// ==== link_tx_ctrl_monitor.sv ====
// assertions on the link transmit controller ports
// bound into every link_tx_ctrl instance
`timescale 1ns/10ps
`default_nettype none
module link_tx_ctrl_monitor
  import link_tx_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic LINK_SYNC_REQUEST_POS,
  input wire logic LINK_SYNC_REQUEST_NEG,
  input wire link_tx_pkg::link_cfg_s CFG,
  input wire link_tx_pkg::symbol_s SYMBOL,
  input wire logic SYMBOL_VALID,
  input wire logic PLL_LOW_BW,
  input wire link_tx_pkg::link_state_e LINK_STATE,
  input wire logic BIST_BUSY,
  input wire logic [15:0] BIST_SIG_A,
  input wire logic [15:0] BIST_SIG_B
);
  logic req;
  logic in_data;
  // request seen on pos leg, neg leg only in differential mode
  assign req = !LINK_SYNC_REQUEST_POS
    && (CFG.sync_cmos || LINK_SYNC_REQUEST_NEG);
  assign in_data = LINK_STATE == ST_DATA;
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);
  a_req_enters_cgs: assert property (
    req [*4] |=> LINK_STATE == ST_CGS)
    else $error("no comma phase after request");
  a_release_leaves: assert property (
    !req [*6] |=> LINK_STATE != ST_CGS)
    else $error("comma phase kept after release");
  a_cgs_comma: assert property (
    LINK_STATE == ST_CGS ##1 LINK_STATE == ST_CGS
    |-> SYMBOL_VALID && SYMBOL == 9'h179)
    else $error("comma phase sends other symbol");
  a_ila_start: assert property (
    $past(LINK_STATE) == ST_CGS && LINK_STATE == ST_ILA
    |-> ##[1:2] SYMBOL == 9'h039)
    else $error("lane alignment does not open with start char");
  a_repl_no_lane: assert property (
    in_data && $past(in_data) && SYMBOL_VALID && SYMBOL.is_k
    && !CFG.lane_sync_en |-> SYMBOL.octet == 8'hfc)
    else $error("wrong replacement without lane sync");
  a_data_k_set: assert property (
    in_data && $past(in_data) && SYMBOL_VALID && SYMBOL.is_k
    |-> SYMBOL.octet == 8'hfc || SYMBOL.octet == 8'h7c)
    else $error("unexpected control char in data");
  a_pll_bw: assert property (
    PLL_LOW_BW != CFG.pll_low_rate)
    else $error("pll bandwidth select wrong");
  a_sig_hold: assert property (
    BIST_BUSY ##1 BIST_BUSY |-> $stable(BIST_SIG_A) && $stable(BIST_SIG_B))
    else $error("signature moved during self-test");
  a_sig_quiet: assert property (
    !BIST_BUSY [*3] |-> $stable(BIST_SIG_A) && $stable(BIST_SIG_B))
    else $error("signature moved while idle");
endmodule : link_tx_ctrl_monitor
bind link_tx_ctrl link_tx_ctrl_monitor i_link_tx_ctrl_monitor (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .CFG(CFG),
  .LINK_SYNC_REQUEST_POS(LINK_SYNC_REQUEST_POS),
  .LINK_SYNC_REQUEST_NEG(LINK_SYNC_REQUEST_NEG),
  .SYMBOL(SYMBOL), .SYMBOL_VALID(SYMBOL_VALID), .PLL_LOW_BW(PLL_LOW_BW),
  .LINK_STATE(LINK_STATE), .BIST_BUSY(BIST_BUSY),
  .BIST_SIG_A(BIST_SIG_A), .BIST_SIG_B(BIST_SIG_B));
`default_nettype wire

// ==== link_rx_model.sv ====
// receiver model driving the sync request pins
// assumes one symbol per core clock cycle
`timescale 1ns/10ps
`default_nettype none
module link_rx_model
  import link_tx_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic want_sync,
  input wire logic single_ended,
  input wire link_tx_pkg::symbol_s symbol,
  input wire logic symbol_valid,
  output logic sync_pos,
  output logic sync_neg
);
  logic hold, tog;
  logic [3:0] commas;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold <= 1'b0;
      tog <= 1'b0;
      commas <= 4'h0;
    end else begin
      tog <= !tog;
      if (want_sync) begin
        hold <= 1'b1;
        commas <= 4'h0;
      end else if (commas == 4'h8) begin
        hold <= 1'b0;
      end else if (hold && symbol_valid && symbol == 9'h179) begin
        commas <= commas + 4'h1;
      end
    end
  end
  assign sync_pos = !hold;
  assign sync_neg = single_ended ? tog : hold;
endmodule : link_rx_model
`default_nettype wire

// ==== link_tx_ctrl_tb.sv ====
// self-checking bench for the link transmit controller
// needs the receiver model and the checker compiled first
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  err_count++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module link_tx_ctrl_tb;
  import link_tx_pkg::*;
  logic core_clk, resetn, pos, neg, want_sync, s_valid, s_ready;
  logic sym_valid, pll_low_bw, bist_busy, in_cgs;
  logic [13:0] sample;
  logic [15:0] sig_a, sig_b, k1, k2;
  link_cfg_s cfg;
  symbol_s sym;
  link_state_e state;
  int err_count, tests_run;
  link_tx_ctrl #(.ILA_MULTIFRAMES(1), .FRAMES_PER_MF(4)) i_link_tx_ctrl (
    .CORE_CLK(core_clk), .RESETN(resetn), .LINK_SYNC_REQUEST_POS(pos),
    .LINK_SYNC_REQUEST_NEG(neg), .CFG(cfg), .SAMPLE(sample),
    .SAMPLE_VALID(s_valid), .SAMPLE_READY(s_ready), .SYMBOL(sym),
    .SYMBOL_VALID(sym_valid), .PLL_LOW_BW(pll_low_bw), .LINK_STATE(state),
    .BIST_BUSY(bist_busy), .BIST_SIG_A(sig_a), .BIST_SIG_B(sig_b));
  link_rx_model i_link_rx_model (.clk(core_clk), .resetn(resetn),
    .want_sync(want_sync), .single_ended(cfg.sync_cmos), .symbol(sym),
    .symbol_valid(sym_valid), .sync_pos(pos), .sync_neg(neg));
  assign in_cgs = state == ST_CGS;
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic give_up(input int n);
    if (n >= 4000) begin
      err_count++;
      final_report();
    end
  endtask : give_up
  task automatic wait_cgs();
    int n;
    n = 0;
    while (in_cgs !== 1'b1 && n < 4000) begin
      @(negedge core_clk);
      n++;
    end
    give_up(n);
  endtask : wait_cgs
  task automatic get_sym(output symbol_s s, input logic skip);
    int n;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while ((!sym_valid || (skip && sym == 9'h179)) && n < 4000);
    give_up(n);
    s = sym;
  endtask : get_sym
  // expected coding of a sample
  function automatic logic [13:0] coded(logic [13:0] s, logic [1:0] f,
    logic inv);
    logic [13:0] v;
    v = inv ? ~s : s;
    if (f != 2'd0)
      v = v ^ 14'h2000;
    if (f == 2'd2)
      v = v ^ (v >> 1);
    return v;
  endfunction : coded
  // receiver side self-synchronising descrambler
  function automatic logic [7:0] descr(input logic [7:0] d,
    inout logic [14:0] st);
    logic [7:0] o;
    for (int b = 7; b >= 0; b--) begin
      o[b] = d[b] ^ st[13] ^ st[14];
      st = {st[13:0], d[b]};
    end
    return o;
  endfunction : descr
  task automatic run_case(input logic [13:0] s, input int n,
    input logic [1:0] f, input logic inv, input logic cm, input logic ls,
    input logic [1:0] ila, input logic sc);
    symbol_s got;
    logic [13:0] v;
    logic [7:0] o;
    logic [14:0] st;
    logic rk;
    st = '0;
    @(posedge core_clk);
    cfg.scramble_en <= sc;
    cfg.data_format <= f;
    cfg.invert <= inv;
    cfg.sync_cmos <= cm;
    cfg.lane_sync_en <= ls;
    cfg.ila_mode <= ila;
    want_sync <= 1'b1;
    wait_cgs();
    repeat (2) get_sym(got, 1'b0);
    `CHK("comma", 9'h179, got)
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      sample <= s;
      s_valid <= 1'b1;
    end
    @(posedge core_clk);
    s_valid <= 1'b0;
    want_sync <= 1'b0;
    @(negedge core_clk);
    if (n == 8)
      `CHK("fifo full", 1'b0, s_ready)
    get_sym(got, 1'b1);
    if (ila != 2'd0) begin
      `CHK("ila start", 9'h039, got)
      repeat (8) get_sym(got, 1'b0);
    end
    v = coded(s, f, inv);
    for (int i = 0; i < n; i++) begin
      if (i > 0)
        get_sym(got, 1'b0);
      o = descr(got.octet, st);
      if (!sc)
        `CHK("octet0", {v[13:6], 1'b0}, got)
      else if (i > 0)
        `CHK("descr0", v[13:6], o)
      get_sym(got, 1'b0);
      o = descr(got.octet, st);
      if (sc) begin
        if (i > 0)
          `CHK("descr1", {v[5:0], 2'b01}, o)
        rk = got.octet == 8'hfc || (ls && i % 4 == 3 && got.octet == 8'h7c);
        `CHK("scr repl", rk, got.is_k)
      end else if (i == 0)
        `CHK("octet1", {v[5:0], 2'b01, 1'b0}, got)
      else if (ls && i % 4 == 3)
        `CHK("mf end", 9'h0f9, got)
      else
        `CHK("frame end", 9'h1f9, got)
    end
    repeat (4) @(negedge core_clk);
    `CHK("drained", 1'b0, sym_valid)
  endtask : run_case
  task automatic run_bist(input logic rst, output logic [15:0] sa);
    int cnt, idle, n;
    @(posedge core_clk);
    cfg.bist_pn_restart <= rst;
    cfg.bist_en <= 1'b1;
    cnt = 0;
    idle = 0;
    n = 0;
    while (idle < 16 && n < 4000) begin
      @(negedge core_clk);
      n++;
      cnt += int'(sym_valid);
      idle = (bist_busy || sym_valid) ? 0 : idle + 1;
    end
    give_up(n);
    `CHK("bist words", 1024, cnt)
    @(posedge core_clk);
    cfg.bist_en <= 1'b0;
    sa = sig_a;
  endtask : run_bist
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    resetn = 1'b0;
    want_sync = 1'b0;
    s_valid = 1'b0;
    sample = 14'h0;
    cfg = '0;
    cfg.tail_bits = 2'b01;
    err_count = 0;
    tests_run = 0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    `CHK("reset symbol", 9'h179, sym)
    `CHK("reset state", ST_IDLE, state)
    @(posedge core_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      cfg.pll_low_rate <= i[0];
      @(negedge core_clk);
      `CHK("pll bw", ~i[0], pll_low_bw)
    end
    run_case(14'h1234, 8, 2'd0, 1'b0, 1'b0, 1'b0, 2'd0, 1'b0);
    run_case(14'h0567, 2, 2'd1, 1'b0, 1'b1, 1'b0, 2'd0, 1'b0);
    run_case(14'h0abc, 8, 2'd2, 1'b0, 1'b0, 1'b1, 2'd1, 1'b0);
    run_case(14'h1f0f, 2, 2'd0, 1'b1, 1'b0, 1'b0, 2'd0, 1'b0);
    run_case(14'h1234, 8, 2'd0, 1'b0, 1'b0, 1'b1, 2'd0, 1'b1);
    run_bist(1'b1, k1);
    run_bist(1'b1, k2);
    `CHK("pn restart", k1, k2)
    `CHK("sig a b", 1'b1, sig_a !== sig_b)
    run_bist(1'b0, k2);
    `CHK("pn continue", 1'b1, k1 !== k2)
    final_report();
  end
endmodule : link_tx_ctrl_tb
`default_nettype wire
